// file: test/csw_area_wait_ctrl_monitor.sv
// Port checker for the area wait-state controller.
// Assumes a bind into csw_area_wait_ctrl; one clock domain.
`timescale 1ns/100ps
module csw_chk (
  input wire       clk_i,
  input wire       reset_i,
  input wire       manual_reset_i,
  input wire       standby_i,
  input wire       psel_i,
  input wire       penable_i,
  input wire [7:0] paddr_i,
  input wire       pready_o,
  input wire       pslverr_o,
  input wire       cyc_start_i,
  input wire       ext_wait_i,
  input wire       cyc_dram_i,
  input wire       cyc_busy_o,
  input wire       cyc_wait_o,
  input wire       cyc_done_o,
  input wire [3:0] cyc_count_o,
  input wire       cyc_ext_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Aborts end a cycle early, so step checks skip them
  wire calm = !manual_reset_i && !standby_i;
  wire unmap = paddr_i != 8'h00 && paddr_i != 8'h04 && paddr_i != 8'h08;
  sequence s_take;
    cyc_start_i && !cyc_busy_o && calm;
  endsequence
  sequence s_fin;
    !cyc_done_o && !cyc_busy_o;
  endsequence
  ready_fixed_a: assert property (pready_o) else $error("pready low");
  unmapped_err_a: assert property (psel_i && penable_i |-> pslverr_o == unmap)
    else $error("pslverr wrong");
  cycle_take_a: assert property (s_take |=> cyc_busy_o) else $error("start lost");
  done_idle_a: assert property (cyc_done_o && calm |=> s_fin) else $error("done stuck");
  zero_done_a: assert property ($rose(cyc_busy_o) && cyc_count_o == 4'h0 |->
    cyc_done_o && !cyc_wait_o) else $error("zero count waited");
  count_step_a: assert property (cyc_wait_o && cyc_count_o > 4'h1 && calm |=>
    cyc_wait_o && cyc_count_o == $past(cyc_count_o) - 4'h1) else $error("bad step");
  ext_flag_a: assert property ($rose(cyc_busy_o) && !$past(cyc_dram_i) |->
    cyc_ext_en_o == (cyc_count_o != 4'h0)) else $error("ext enable wrong");
  no_stretch_a: assert property (cyc_wait_o && cyc_count_o == 4'h1 && !cyc_ext_en_o
    && calm |=> !cyc_wait_o && cyc_done_o) else $error("stretched");
  abort_idle_a: assert property (!calm |=> !cyc_busy_o) else $error("abort ignored");
  wait_busy_a: assert property (cyc_wait_o |-> cyc_busy_o) else $error("wait idle");
  ext_stretch_a: assert property (cyc_wait_o && cyc_count_o == 4'h1 && cyc_ext_en_o
    && ext_wait_i && calm |=> cyc_wait_o && cyc_count_o == 4'h1)
    else $error("ext wait ignored");
endmodule // csw_chk

// file: test/csw_mem_model.sv
// External memory model: asks one extra wait per cycle on request.
// Assumes the controller samples ext wait in its final wait cycle.
`timescale 1ns/100ps
module csw_mem_model (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       hold_i,
  input  wire       cyc_wait_i,
  input  wire [3:0] cyc_count_i,
  output wire       ext_wait_o
);
  reg used;
  // Single request only, so the stretch stays bounded
  assign ext_wait_o = hold_i && cyc_wait_i && cyc_count_i == 4'h1 && !used;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i || !cyc_wait_i)
      used <= 1'b0;
    else if (ext_wait_o)
      used <= 1'b1;
  end
endmodule // csw_mem_model

// file: test/tb_top.sv
// Bench for the area wait-state controller over APB.
// Assumes zero-wait APB slave and the memory model on ext wait.
`timescale 1ns/100ps
module tb_top;
  reg          clk_i = 1'b0;
  reg          reset_i = 1'b1;
  reg          manual_reset_i = 1'b0;
  reg          standby_i = 1'b0;
  reg          psel_i = 1'b0;
  reg          penable_i = 1'b0;
  reg          pwrite_i = 1'b0;
  reg  [7:0]   paddr_i = 8'h00;
  reg  [31:0]  pwdata_i = 32'h0000_0000;
  reg  [3:0]   pstrb_i = 4'hf;
  reg          cyc_start_i = 1'b0;
  reg  [1:0]   cyc_area_i = 2'h0;
  reg          cyc_dram_i = 1'b0;
  reg          cyc_dma_single_i = 1'b0;
  reg  [1:0]   dram_norm_wait_i = 2'h0;
  reg          hold = 1'b0;
  wire [31:0]  prdata_o;
  wire [3:0]   cyc_count_o;
  wire         pready_o, pslverr_o, ext_wait_i, cyc_busy_o, cyc_wait_o, cyc_done_o, cyc_ext_en_o;
  integer      n_mismatch = 0, check_count = 0, ticks = 0, wcnt = 0, i, j;
  logic [15:0] rd_q[$];
  logic [4:0]  wt_q[$];
  logic [15:0] area_m, dma_m, v;
  logic [3:0]  n;
  logic        h;
  always #5 clk_i = ~clk_i;
  csw_area_wait_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .manual_reset_i(manual_reset_i),
    .standby_i(standby_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cyc_start_i(cyc_start_i),
    .cyc_area_i(cyc_area_i), .cyc_dram_i(cyc_dram_i), .cyc_dma_single_i(cyc_dma_single_i),
    .dram_norm_wait_i(dram_norm_wait_i), .ext_wait_i(ext_wait_i), .cyc_busy_o(cyc_busy_o),
    .cyc_wait_o(cyc_wait_o), .cyc_done_o(cyc_done_o), .cyc_count_o(cyc_count_o),
    .cyc_ext_en_o(cyc_ext_en_o));
  csw_mem_model i_mem (.clk_i(clk_i), .reset_i(reset_i), .hold_i(hold),
    .cyc_wait_i(cyc_wait_o), .cyc_count_i(cyc_count_o), .ext_wait_o(ext_wait_i));
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cmp_rd(input string what, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task cmp_wt(input string what, input logic [4:0] e, input logic [4:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", what, e, s);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= ($urandom << 16) | d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    cmp_wt("pslverr", {4'h0, err}, {4'h0, pslverr_o});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 16'h0000, 1'b0);
  endtask
  task go(input logic [1:0] ar, input logic dr, input logic dm, input logic hd,
          input logic [4:0] e);
    @(posedge clk_i);
    cyc_start_i <= 1'b1;
    cyc_area_i <= ar;
    cyc_dram_i <= dr;
    cyc_dma_single_i <= dm;
    hold <= hd;
    wt_q.push_back(e);
    @(posedge clk_i);
    cyc_start_i <= 1'b0;
  endtask
  task fin;
    do @(posedge clk_i); while (cyc_done_o !== 1'b1);
  endtask
  // Result watcher: read data and waits per bus cycle
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && rd_q.size() > 0)
      cmp_rd("prdata", rd_q.pop_front(), prdata_o[15:0]);
    if (cyc_wait_o === 1'b1)
      wcnt++;
    if (cyc_done_o === 1'b1 && wt_q.size() > 0) begin
      cmp_wt("waits", wt_q.pop_front(), wcnt[4:0]);
      wcnt = 0;
    end
    if (cyc_busy_o !== 1'b1)
      wcnt = 0;
    ticks++;
    if (ticks > 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(32'h3e20));
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 16'hffff);
    rd(8'h04, 16'h000f);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      area_m = (i == 0) ? 16'h0f30 : $urandom;
      apb(1'b1, 8'h00, area_m, 1'b0);
      rd(8'h00, area_m);
      for (j = 0; j < 4; j++) begin
        n = area_m >> (4 * j);
        h = (i == 0) | $urandom;
        go(j, 1'b0, 1'b0, h, n + (h && n != 4'h0));
        fin;
      end
    end
    v = $urandom;
    apb(1'b1, 8'h04, v, 1'b0);
    rd(8'h04, v & 16'h003f);
    apb(1'b1, 8'h0c, 16'h1234, 1'b1);
    rd(8'h00, area_m);
    pstrb_i <= 4'h1;
    apb(1'b1, 8'h00, ~area_m, 1'b0);
    pstrb_i <= 4'hf;
    area_m[7:0] = ~area_m[7:0];
    rd(8'h00, area_m);
    $display("test registers and areas done");
    for (i = 0; i < 4; i++) begin
      dma_m = {10'h000, i[1:0], 4'($urandom)};
      apb(1'b1, 8'h04, dma_m, 1'b0);
      dram_norm_wait_i <= ~i[1:0];
      go($urandom, 1'b1, 1'b1, 1'b1, i + i[1]);
      fin;
      n = dma_m[3:0];
      go(i, 1'b0, 1'b1, 1'b1, n + (n != 4'h0));
      fin;
      go(i, 1'b1, 1'b0, 1'b1, {3'h0, ~i[1:0]} + !i[1]);
      fin;
    end
    $display("test single address done");
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      cyc_area_i <= 2'h2;
      cyc_dram_i <= 1'b0;
      cyc_dma_single_i <= 1'b0;
      cyc_start_i <= 1'b1;
      @(posedge clk_i);
      cyc_start_i <= 1'b0;
      manual_reset_i <= (i == 0);
      standby_i <= (i == 1);
      @(posedge clk_i);
      manual_reset_i <= 1'b0;
      standby_i <= 1'b0;
      rd(8'h00, area_m);
      rd(8'h04, dma_m);
    end
    apb(1'b1, 8'h00, 16'h0090, 1'b0);
    go(2'h1, 1'b0, 1'b0, 1'b0, 5'd9);
    rd(8'h08, 16'h0087);
    apb(1'b1, 8'h00, 16'h0000, 1'b0);
    fin;
    go(2'h1, 1'b0, 1'b0, 1'b1, 5'd0);
    fin;
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 16'hffff);
    rd(8'h04, 16'h000f);
    $display("test resets and late write done");
    wrap_up;
  end
endmodule // tb_top
bind csw_area_wait_ctrl csw_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
  .manual_reset_i(manual_reset_i), .standby_i(standby_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .cyc_start_i(cyc_start_i), .ext_wait_i(ext_wait_i), .cyc_dram_i(cyc_dram_i),
  .cyc_busy_o(cyc_busy_o),
  .cyc_wait_o(cyc_wait_o), .cyc_done_o(cyc_done_o), .cyc_count_o(cyc_count_o),
  .cyc_ext_en_o(cyc_ext_en_o));

// file: verilog/csw_area_wait_ctrl.v
// Chip-select area wait-state controller with APB register access.
// Assumes an APB master on clk_i and a bus-cycle sequencer upstream.
//
// Function
// R01: 16-bit read/write register holds a 0..15 wait count per area.
// R02: Power-on reset loads all ones into the area wait register.
// R03: Manual reset and standby leave both wait registers untouched.
// R04: Area 3 in bits 15:12, area 2 11:8, 1 7:4, 0 3:0.
// R05: Count zero inserts no waits and ignores external wait input.
// R06: Count N inserts N waits and honours external wait input.
// R07: Second 16-bit register sets DMA single-address DRAM and area waits.
// R08: Power-on reset loads the DMA wait register with 000F.
// R09: DMA register bits 15:6 are reserved and read zero.
// R10: Software writes zero into DMA register bits 15:6.
// R11: DRAM field codes give 2..5 cycles; external wait from code 2. The code inserts 0..3 waits for codes 0..3.
// R12: DMA DRAM field acts apart from normal DRAM wait fields.
// R13: DMA area field gives 0..15 waits; nonzero enables external wait.
// R14: DMA area field replaces per-area counts during single-address DMA.
// R15: Software programs the DMA register before single-address DMA.
// R16: New counts apply from the next bus cycle; current one completes.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "csw_consts.vh"

module csw_area_wait_ctrl (
  // Clock and resets
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        manual_reset_i,
  input  wire        standby_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // Bus cycle request
  input  wire        cyc_start_i,
  input  wire [1:0]  cyc_area_i,
  input  wire        cyc_dram_i,
  input  wire        cyc_dma_single_i,
  input  wire [1:0]  dram_norm_wait_i,
  input  wire        ext_wait_i,
  // Bus cycle state
  output wire        cyc_busy_o,
  output wire        cyc_wait_o,
  output wire        cyc_done_o,
  output wire [3:0]  cyc_count_o,
  output wire        cyc_ext_en_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Pick one area count out of the area register
  function [3:0] area_field;
    input [15:0] regv;
    input [1:0]  area;
    begin
      if (area == `CSW_SEL_A0) begin
        area_field = regv[`CSW_AREA0]; // R04
      end else if (area == `CSW_SEL_A1) begin
        area_field = regv[`CSW_AREA1]; // R04
      end else if (area == `CSW_SEL_A2) begin
        area_field = regv[`CSW_AREA2]; // R04
      end else begin
        area_field = regv[`CSW_AREA3]; // R04
      end
    end
  endfunction

  // DRAM code to inserted waits: codes 0..3 give 0..3 waits
  function [3:0] dram_waits;
    input [1:0] code;
    begin
      dram_waits = {`CSW_PAD2, code}; // R11
    end
  endfunction

  // External wait enabled only for the two upper codes
  function dram_ext_en;
    input [1:0] code;
    begin
      dram_ext_en = code[`CSW_DDW_HI]; // R11
    end
  endfunction

  // Byte-lane write merge for a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  strb;
    begin
      lane_merge = old;
      if (strb[`CSW_STRB_HB]) begin
        lane_merge[`CSW_HB] = wd[`CSW_HB];
      end
      if (strb[`CSW_STRB_LB]) begin
        lane_merge[`CSW_LB] = wd[`CSW_LB];
      end
    end
  endfunction

  // One-hot register select from the byte address
  function [2:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = `CSW_SEL_NONE;
      if (addr == `CSW_OFS_AREA) begin
        reg_select = `CSW_SEL_AREA;
      end else if (addr == `CSW_OFS_DMA) begin
        reg_select = `CSW_SEL_DMA;
      end else if (addr == `CSW_OFS_STAT) begin
        reg_select = `CSW_SEL_STAT;
      end
    end
  endfunction

  // Any nonzero count opens the external wait input
  function count_ext_en;
    input [3:0] count;
    begin
      count_ext_en = (count != `CSW_ZERO4); // R05 R06 R13
    end
  endfunction

  // Sequencer state packed for software polling
  function [31:0] status_word;
    input       busy;
    input       waiting;
    input       ext_en;
    input [3:0] count;
    begin
      status_word              = `CSW_ZERO32;
      status_word[`CSW_ST_BUSY] = busy;
      status_word[`CSW_ST_WAIT] = waiting;
      status_word[`CSW_ST_EXT]  = ext_en;
      status_word[`CSW_ST_CNT]  = count;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [15:0] area_wait_count;
  reg  [15:0] dma_single_wait_count;
  reg  [31:0] rd_mux;
  reg         addr_hit;
  reg  [3:0]  sel_count;
  reg         sel_ext_en;
  wire        apb_setup;
  wire        apb_access;
  wire [2:0]  rsel;
  wire        wr_area;
  wire        wr_dma;
  wire        abort;
  wire [1:0]  strb_lo;
  wire [15:0] wd_lo;
  wire        t_busy;
  wire        t_wait;
  wire [3:0]  t_count;
  wire        t_ext_en;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign apb_setup  = psel_i & ~penable_i;
  assign apb_access = psel_i & penable_i;
  assign strb_lo    = pstrb_i[`CSW_STRB16];
  assign rsel       = reg_select(paddr_i);
  assign wd_lo      = pwdata_i[`CSW_REG16];

  // Zero-wait slave: every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_access & ~addr_hit;

  assign wr_area = apb_access & pwrite_i & rsel[`CSW_RS_AREA];
  assign wr_dma  = apb_access & pwrite_i & rsel[`CSW_RS_DMA];

  always @* begin
    addr_hit = 1'b0;
    if (rsel[`CSW_RS_AREA]) begin
      addr_hit = 1'b1;
    end else if (rsel[`CSW_RS_DMA]) begin
      addr_hit = 1'b1;
    end else if (rsel[`CSW_RS_STAT]) begin
      addr_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    rd_mux = `CSW_ZERO32;
    if (rsel[`CSW_RS_AREA]) begin
      rd_mux[`CSW_REG16] = area_wait_count; // R01
    end else if (rsel[`CSW_RS_DMA]) begin
      rd_mux[`CSW_REG16] = dma_single_wait_count & `CSW_DMA_MASK; // R09
    end else if (rsel[`CSW_RS_STAT]) begin
      rd_mux = status_word(t_busy, t_wait, t_ext_en, t_count);
    end
  end

  // Read data is captured in the setup cycle and held to the access edge
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= `CSW_ZERO32;
    end else if (apb_setup && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  // ----------------------------------------
  // Wait control registers
  // ----------------------------------------
  // Only the power-on reset loads their reset values; manual reset and standby do not
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      area_wait_count <= `CSW_AREA_RST; // R02
    end else if (wr_area) begin
      area_wait_count <= lane_merge(area_wait_count, wd_lo, strb_lo); // R01
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dma_single_wait_count <= `CSW_DMA_RST; // R08
    end else if (wr_dma) begin
      // Reserved bits dropped, so a stray one never reaches the logic
      dma_single_wait_count <= lane_merge(dma_single_wait_count, wd_lo, strb_lo)
                               & `CSW_DMA_MASK; // R09 R07
    end
  end

  // ----------------------------------------
  // Count selection
  // ----------------------------------------
  // Normal DRAM counts come from outside and never mix with the DMA field
  always @* begin
    sel_count  = `CSW_ZERO4;
    sel_ext_en = 1'b0;
    if (cyc_dma_single_i && cyc_dram_i) begin
      sel_count  = dram_waits(dma_single_wait_count[`CSW_DDW]); // R11 R12
      sel_ext_en = dram_ext_en(dma_single_wait_count[`CSW_DDW]); // R11
    end else if (cyc_dma_single_i) begin
      sel_count  = dma_single_wait_count[`CSW_DSW]; // R13 R14
      sel_ext_en = count_ext_en(dma_single_wait_count[`CSW_DSW]); // R13
    end else if (cyc_dram_i) begin
      sel_count  = dram_waits(dram_norm_wait_i); // R12
      sel_ext_en = dram_ext_en(dram_norm_wait_i); // R12
    end else begin
      sel_count  = area_field(area_wait_count, cyc_area_i); // R01
      sel_ext_en = count_ext_en(sel_count); // R05 R06
    end
  end

  // ----------------------------------------
  // Wait sequencer
  // ----------------------------------------
  // Manual reset and standby end the cycle but keep the registers
  assign abort = manual_reset_i | standby_i; // R03

  csw_wait_timer u_timer (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .abort_i    (abort),
    .start_i    (cyc_start_i),
    .count_i    (sel_count),
    .ext_en_i   (sel_ext_en),
    .ext_wait_i (ext_wait_i),
    .busy_o     (t_busy),
    .wait_o     (t_wait),
    .done_o     (cyc_done_o),
    .count_o    (t_count),
    .ext_en_o   (t_ext_en)
  );

  assign cyc_busy_o   = t_busy;
  assign cyc_wait_o   = t_wait;
  assign cyc_count_o  = t_count;
  assign cyc_ext_en_o = t_ext_en;

endmodule // csw_area_wait_ctrl

// file: verilog/csw_consts.vh
// Constants for the chip-select area wait-state controller.
// Assumes inclusion by bare name from the design files.
`ifndef CSW_CONSTS_VH
`define CSW_CONSTS_VH

// ----------------------------------------
// Register offsets on the bus
// ----------------------------------------
`define CSW_OFS_AREA   8'h00
`define CSW_OFS_DMA    8'h04
`define CSW_OFS_STAT   8'h08

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CSW_AREA_RST   16'hffff
`define CSW_DMA_RST    16'h000f
`define CSW_DMA_MASK   16'h003f
`define CSW_ZERO16     16'h0000
`define CSW_ZERO32     32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSW_AREA0      3:0
`define CSW_AREA1      7:4
`define CSW_AREA2      11:8
`define CSW_AREA3      15:12
`define CSW_DSW        3:0
`define CSW_DDW        5:4
`define CSW_DDW_HI     1
`define CSW_HB         15:8
`define CSW_LB         7:0
`define CSW_REG16      15:0
`define CSW_STRB_HB    1
`define CSW_STRB_LB    0
`define CSW_STRB16     1:0
`define CSW_RS_AREA    0
`define CSW_RS_DMA     1
`define CSW_RS_STAT    2
`define CSW_ST_BUSY    0
`define CSW_ST_WAIT    1
`define CSW_ST_EXT     2
`define CSW_ST_CNT     7:4

// ----------------------------------------
// Small codes
// ----------------------------------------
`define CSW_SEL_A0     2'h0
`define CSW_SEL_A1     2'h1
`define CSW_SEL_A2     2'h2
`define CSW_SEL_NONE   3'h0
`define CSW_SEL_AREA   3'h1
`define CSW_SEL_DMA    3'h2
`define CSW_SEL_STAT   3'h4
`define CSW_PAD2       2'h0
`define CSW_ZERO4      4'h0
`define CSW_ONE4       4'h1

`endif

// file: verilog/csw_wait_timer.v
// Wait-cycle sequencer for one external bus cycle.
// Assumes start pulses only while not busy; ext wait synchronous.
`timescale 1ns/100ps
`include "csw_consts.vh"

module csw_wait_timer (
  // Clock and reset
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       abort_i,
  // Cycle request
  input  wire       start_i,
  input  wire [3:0] count_i,
  input  wire       ext_en_i,
  input  wire       ext_wait_i,
  // Cycle state
  output wire       busy_o,
  output wire       wait_o,
  output wire       done_o,
  output wire [3:0] count_o,
  output wire       ext_en_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] cnt;
  reg [3:0] next_cnt;
  reg       ext_en;
  reg       next_ext_en;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    next_state  = state;
    next_cnt    = cnt;
    next_ext_en = ext_en;
    case (state)
      ST_IDLE: begin
        if (start_i) begin
          // Settings latched here; later writes wait for next cycle
          next_cnt    = count_i; // R16
          next_ext_en = ext_en_i; // R16
          if (count_i == `CSW_ZERO4) begin
            next_state = ST_DONE; // R05
          end else begin
            next_state = ST_WAIT; // R06
          end
        end
      end
      ST_WAIT: begin
        if (cnt != `CSW_ONE4) begin
          next_cnt = cnt - `CSW_ONE4; // R06
        end else if (ext_en && ext_wait_i) begin
          next_state = ST_WAIT; // R06
        end else begin
          next_cnt   = `CSW_ZERO4;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (abort_i) begin
      next_state = ST_IDLE;
      next_cnt   = `CSW_ZERO4;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state  <= ST_IDLE;
      cnt    <= `CSW_ZERO4;
      ext_en <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      ext_en <= next_ext_en;
    end
  end

  assign busy_o   = ~state[0];
  assign wait_o   = state[1];
  assign done_o   = state[2];
  assign count_o  = cnt;
  assign ext_en_o = ext_en;

endmodule // csw_wait_timer
